// file: verilog/gdsc_top.sv
// Gate drive supply control: voltage set point, pump clock, pre-charge, lockout, pull-downs
//
// Overview of operation
// RULE1: One two-bit drive voltage select picks one of four levels, shared by both pumps.
// RULE2: A two-bit pump clock select picks one of four pump clock frequencies.
// RULE3: With spread spectrum on, the pump clock period sweeps between bounded limits.
// RULE4: The host sets the low rail pre-charge enable bit to request pre-charge.
// RULE5: Pre-charge runs before the driver enable pin asserts, once per power-up only.
// RULE6: While the low side rail lockout holds, PWM does not reach the gate outputs.
// RULE7: Each rail lockout releases when its rising comparator trips, then PWM may pass.
// RULE8: Low side rail below its falling threshold forces outputs high-Z and reports a fault.
// RULE9: High side rail below its falling threshold forces outputs high-Z and reports a fault.
// RULE10: Either rail lockout fault drives the active-low fault pin low.
// RULE11: The weak pull-down on every gate output is always connected.
// RULE12: While the driver is off, a gate whose voltage rises gets a strong pull-down.
// RULE13: Comparator and gate sense inputs are synchronised before use.
`include "gdsc_map.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Three-stage synchroniser; output follows once stages two and three agree
module gdsc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	// Data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_sync;
	// Per bit: accept a new level only when the last two stages match
	always_comb begin
		for (int b = 0; b < WIDTH; b++) begin
			next_sync[b] = (stage2[b] == stage3[b]) ? stage3[b] : o_sync[b];
		end
	end
	// Stage one is read only by stage two
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			o_sync <= '0;
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
			o_sync <= next_sync;
		end
	end
endmodule
////////////////////////////////////////////////////////////////////////////////
// Top level
module gdsc_top #(
	parameter int NUM_GATES     = 6,
	parameter int PRECHARGE_CYC = `GDSC_PRECHARGE_CYC
) (
	// Clock and power-up reset
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_rst_n,
	// Configuration written by the host
	input  wire gdsc_pkg::gdsc_cfg_t     i_cfg,
	input  wire logic                    i_fault_clear,
	// Host pins
	input  wire logic                    i_driver_enable_pin,
	input  wire logic [NUM_GATES-1:0]    i_pwm,
	// Analog comparators
	input  wire gdsc_pkg::gdsc_rail_cmp_t i_low_side_pump_rail,
	input  wire gdsc_pkg::gdsc_rail_cmp_t i_high_side_pump_rail,
	input  wire logic [NUM_GATES-1:0]    i_gate_vgs_high,
	// Supply control outputs
	output logic [1:0]                   o_drive_voltage_target,
	output logic                         o_pump_clk,
	output logic                         o_precharge_on,
	// Gate outputs
	output logic [NUM_GATES-1:0]         o_gate_drive,
	output logic [NUM_GATES-1:0]         o_gate_oe,
	output logic [NUM_GATES-1:0]         o_weak_pd,
	output logic [NUM_GATES-1:0]         o_strong_pd,
	// Status and open-drain fault pin
	output logic                         o_low_rail_lockout,
	output logic                         o_high_rail_lockout,
	output logic                         o_low_rail_fault,
	output logic                         o_high_rail_fault,
	output logic                         o_fault_pin_n,
	output logic                         o_fault_pin_n_oe
);
	// Elaboration checks
	if (NUM_GATES < 1 || NUM_GATES > 32) begin : g_bad_gates
		$error("NUM_GATES out of range");
	end
	if (PRECHARGE_CYC < 1 || PRECHARGE_CYC > 65535) begin : g_bad_pc
		$error("PRECHARGE_CYC out of range");
	end
	////////////////////////////////////////////////////////////////////////////
	// Synchronisers for everything that arrives from outside this clock
	localparam int SYNC_W = 2 * NUM_GATES + 5;
	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_out;
	logic                 drv_en;
	logic [NUM_GATES-1:0] pwm;
	logic [NUM_GATES-1:0] vgs_high;
	logic                 ls_rise;
	logic                 ls_fall_ok;
	logic                 hs_rise;
	logic                 hs_fall_ok;
	// Comparators and sense bits are never used raw [RULE13]
	assign sync_in = {i_driver_enable_pin, i_pwm, i_gate_vgs_high,
		i_low_side_pump_rail.above_rise, i_low_side_pump_rail.above_fall,
		i_high_side_pump_rail.above_rise, i_high_side_pump_rail.above_fall};
	gdsc_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (sync_in),
		.o_sync    (sync_out)
	);
	assign drv_en     = sync_out[SYNC_W-1];
	assign pwm        = sync_out[SYNC_W-2 -: NUM_GATES];
	assign vgs_high   = sync_out[NUM_GATES+3 -: NUM_GATES];
	assign ls_rise    = sync_out[3];
	assign ls_fall_ok = sync_out[2];
	assign hs_rise    = sync_out[1];
	assign hs_fall_ok = sync_out[0];
	////////////////////////////////////////////////////////////////////////////
	// Drive voltage set point; one code steers both pumps
	logic [1:0] next_vtarget;
	always_comb begin
		next_vtarget = i_cfg.drive_voltage_select; // [RULE1]
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_drive_voltage_target <= `GDSC_VSEL_12V;
		end else begin
			o_drive_voltage_target <= next_vtarget;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Pump clock divider with optional triangular spread of the half period
	logic [7:0] div_cnt;
	logic [7:0] spread_ofs;
	logic       spread_up;
	logic [7:0] base_half;
	logic [7:0] half_len;
	logic [7:0] next_div_cnt;
	logic [7:0] next_spread_ofs;
	logic       next_spread_up;
	logic       next_pump_clk;
	always_comb begin
		// Base half period from the selected frequency [RULE2]
		unique case (i_cfg.pump_clock_select)
			2'h0: base_half = 8'(`GDSC_HALF0);
			2'h1: base_half = 8'(`GDSC_HALF1);
			2'h2: base_half = 8'(`GDSC_HALF2);
			2'h3: base_half = 8'(`GDSC_HALF3);
		endcase
		half_len        = base_half + spread_ofs;
		next_div_cnt    = div_cnt + 8'h01;
		next_pump_clk   = o_pump_clk;
		next_spread_ofs = spread_ofs;
		next_spread_up  = spread_up;
		if (div_cnt >= half_len - 8'h01) begin
			next_div_cnt  = 8'h00;
			next_pump_clk = ~o_pump_clk;
			// Step the sweep once per full pump period, at the falling edge
			if (o_pump_clk) begin
				if (!i_cfg.spread_enable) begin
					next_spread_ofs = 8'h00;
					next_spread_up  = 1'b1;
				end else if (spread_up) begin // [RULE3]
					if (spread_ofs >= `GDSC_SPREAD_MAX - 8'h01) begin
						next_spread_up = 1'b0;
					end
					next_spread_ofs = spread_ofs + 8'h01;
				end else begin
					if (spread_ofs <= 8'h01) begin
						next_spread_up = 1'b1;
					end
					next_spread_ofs = spread_ofs - 8'h01;
				end
			end
		end
	end
	// A select change takes effect at the next edge compare; no glitch below one cycle
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_cnt    <= 8'h00;
			spread_ofs <= 8'h00;
			spread_up  <= 1'b1;
			o_pump_clk <= 1'b0;
		end else begin
			div_cnt    <= next_div_cnt;
			spread_ofs <= next_spread_ofs;
			spread_up  <= next_spread_up;
			o_pump_clk <= next_pump_clk;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// One-shot pre-charge of the low side rail before the driver is enabled
	gdsc_pkg::gdsc_pc_state_t pc_state;
	gdsc_pkg::gdsc_pc_state_t next_pc_state;
	logic [15:0] pc_cnt;
	logic [15:0] next_pc_cnt;
	logic        next_precharge_on;
	always_comb begin
		next_pc_state = pc_state;
		next_pc_cnt   = pc_cnt;
		unique case (pc_state)
			gdsc_pkg::GDSC_PC_WAIT: begin
				// First enable after power-up ends the chance for good [RULE5]
				if (drv_en) begin
					next_pc_state = gdsc_pkg::GDSC_PC_DONE;
				end else if (i_cfg.low_rail_precharge_enable) begin // [RULE4]
					next_pc_state = gdsc_pkg::GDSC_PC_RUN;
					next_pc_cnt   = 16'(PRECHARGE_CYC - 1);
				end
			end
			gdsc_pkg::GDSC_PC_RUN: begin
				// Stops at the time limit or when the enable pin arrives [RULE5]
				if (drv_en || pc_cnt == 16'h0000) begin
					next_pc_state = gdsc_pkg::GDSC_PC_DONE;
				end else begin
					next_pc_cnt = pc_cnt - 16'h0001;
				end
			end
			gdsc_pkg::GDSC_PC_DONE: begin
				next_pc_state = gdsc_pkg::GDSC_PC_DONE; // Left only by power-up reset
			end
			default: begin
				next_pc_state = gdsc_pkg::GDSC_PC_DONE;
			end
		endcase
		next_precharge_on = (next_pc_state == gdsc_pkg::GDSC_PC_RUN);
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pc_state       <= gdsc_pkg::GDSC_PC_WAIT;
			pc_cnt         <= 16'h0000;
			o_precharge_on <= 1'b0;
		end else begin
			pc_state       <= next_pc_state;
			pc_cnt         <= next_pc_cnt;
			o_precharge_on <= next_precharge_on;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Rail lockouts and sticky faults
	logic next_ls_lock;
	logic next_hs_lock;
	logic next_ls_fault;
	logic next_hs_fault;
	logic next_fault_oe;
	always_comb begin
		next_ls_lock  = o_low_rail_lockout;
		next_hs_lock  = o_high_rail_lockout;
		next_ls_fault = o_low_rail_fault;
		next_hs_fault = o_high_rail_fault;
		// Release on the rising comparator [RULE7]
		if (o_low_rail_lockout && ls_rise) begin
			next_ls_lock = 1'b0;
		end
		if (o_high_rail_lockout && hs_rise) begin
			next_hs_lock = 1'b0;
		end
		// Software clear first, so a fall in the same cycle still wins
		if (i_fault_clear) begin
			next_ls_fault = 1'b0;
			next_hs_fault = 1'b0;
		end
		// Falling threshold after release relocks and reports [RULE8]
		if (!o_low_rail_lockout && !ls_fall_ok) begin
			next_ls_lock  = 1'b1;
			next_ls_fault = 1'b1;
		end
		// Same for the high side rail [RULE9]
		if (!o_high_rail_lockout && !hs_fall_ok) begin
			next_hs_lock  = 1'b1;
			next_hs_fault = 1'b1;
		end
		// Open-drain fault pin pulls low while any fault stands [RULE10]
		next_fault_oe = next_ls_fault || next_hs_fault;
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_low_rail_lockout  <= `GDSC_RST_LOCKOUT;
			o_high_rail_lockout <= `GDSC_RST_LOCKOUT;
			o_low_rail_fault    <= `GDSC_RST_FAULT;
			o_high_rail_fault   <= `GDSC_RST_FAULT;
			o_fault_pin_n_oe    <= 1'b0;
			o_fault_pin_n       <= 1'b0;
		end else begin
			o_low_rail_lockout  <= next_ls_lock;
			o_high_rail_lockout <= next_hs_lock;
			o_low_rail_fault    <= next_ls_fault;
			o_high_rail_fault   <= next_hs_fault;
			o_fault_pin_n_oe    <= next_fault_oe;
			o_fault_pin_n       <= 1'b0; // Driven value is always low
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Gate outputs, high-Z control and pull-downs
	logic                 drive_ok;
	logic [NUM_GATES-1:0] next_gate_drive;
	logic [NUM_GATES-1:0] next_gate_oe;
	logic [NUM_GATES-1:0] next_strong_pd;
	always_comb begin
		// Uses next lockout values so a falling rail cuts the same edge it is seen
		drive_ok = drv_en && !next_ls_lock && !next_hs_lock; // [RULE6] [RULE8] [RULE9]
		// PWM passes only after both releases [RULE7]
		next_gate_drive = drive_ok ? pwm : '0;
		next_gate_oe    = drive_ok ? '1 : '0;
		// Strong pull-down on a rising gate while the driver is off [RULE12]
		next_strong_pd  = drive_ok ? '0 : vgs_high;
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_gate_drive <= '0;
			o_gate_oe    <= '0;
			o_strong_pd  <= '0;
			o_weak_pd    <= '1;
		end else begin
			o_gate_drive <= next_gate_drive;
			o_gate_oe    <= next_gate_oe;
			o_strong_pd  <= next_strong_pd;
			o_weak_pd    <= '1; // Never released, in any state [RULE11]
		end
	end
endmodule
`default_nettype wire

// file: verilog/gdsc_map.svh
// Constant map for the gate drive supply control block
`ifndef GDSC_MAP_SVH
`define GDSC_MAP_SVH

// Reference clock rate in kHz
`define GDSC_REF_CLK_KHZ 40000

// Drive voltage select codes
`define GDSC_VSEL_12V 2'h0
`define GDSC_VSEL_15V 2'h1
`define GDSC_VSEL_10V 2'h2
`define GDSC_VSEL_7V  2'h3

// Pump clock frequencies in kHz for each pump clock select code
`define GDSC_PCLK0_KHZ 400
`define GDSC_PCLK1_KHZ 500
`define GDSC_PCLK2_KHZ 800
`define GDSC_PCLK3_KHZ 1000

// Half-period counts derived from the rates
`define GDSC_HALF0 (`GDSC_REF_CLK_KHZ / (2 * `GDSC_PCLK0_KHZ))
`define GDSC_HALF1 (`GDSC_REF_CLK_KHZ / (2 * `GDSC_PCLK1_KHZ))
`define GDSC_HALF2 (`GDSC_REF_CLK_KHZ / (2 * `GDSC_PCLK2_KHZ))
`define GDSC_HALF3 (`GDSC_REF_CLK_KHZ / (2 * `GDSC_PCLK3_KHZ))

// Spread spectrum: largest extra half-period in reference cycles
`define GDSC_SPREAD_MAX 8'h07

// Pre-charge duration in microseconds and in reference cycles
`define GDSC_PRECHARGE_US 100
`define GDSC_PRECHARGE_CYC ((`GDSC_PRECHARGE_US * `GDSC_REF_CLK_KHZ) / 1000)

// Reset values
`define GDSC_RST_LOCKOUT 1'b1
`define GDSC_RST_FAULT   1'b0

`endif

// file: verilog/gdsc_pkg.sv
// Types shared by the gate drive supply control block
`default_nettype none
package gdsc_pkg;
	// Software configuration carried as one group
	typedef struct packed {
		logic       spread_enable;
		logic       low_rail_precharge_enable;
		logic [1:0] pump_clock_select;
		logic [1:0] drive_voltage_select;
	} gdsc_cfg_t;

	// Rail threshold comparator pair: above rising and above falling threshold
	typedef struct packed {
		logic above_rise;
		logic above_fall;
	} gdsc_rail_cmp_t;

	// Pre-charge sequence states
	typedef enum logic [1:0] {
		GDSC_PC_WAIT = 2'b00,
		GDSC_PC_RUN  = 2'b01,
		GDSC_PC_DONE = 2'b10
	} gdsc_pc_state_t;
endpackage
`default_nettype wire

// file: tb/gdsc_props.sv
// Concurrent checks on the gate drive supply control ports
`default_nettype none
module gdsc_props #(
	parameter int NUM_GATES = 6
) (
	// Clock and reset
	input wire logic                     i_ref_clk,
	input wire logic                     i_rst_n,
	// Inputs watched
	input wire gdsc_pkg::gdsc_cfg_t      i_cfg,
	input wire gdsc_pkg::gdsc_rail_cmp_t i_low_side_pump_rail,
	// Outputs watched
	input wire logic [1:0]               o_drive_voltage_target,
	input wire logic                     o_precharge_on,
	input wire logic [NUM_GATES-1:0]     o_gate_drive,
	input wire logic [NUM_GATES-1:0]     o_gate_oe,
	input wire logic [NUM_GATES-1:0]     o_weak_pd,
	input wire logic [NUM_GATES-1:0]     o_strong_pd,
	input wire logic                     o_low_rail_lockout,
	input wire logic                     o_high_rail_lockout,
	input wire logic                     o_low_rail_fault,
	input wire logic                     o_high_rail_fault,
	input wire logic                     o_fault_pin_n,
	input wire logic                     o_fault_pin_n_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic pc_last;
	logic pc_seen;
	logic next_pc_seen;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Remember that a pre-charge ended; a new power-up clears it
	always_comb next_pc_seen = pc_seen | (pc_last & ~o_precharge_on);
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{pc_last, pc_seen} <= 2'h0;
		end else begin
			{pc_last, pc_seen} <= {o_precharge_on, next_pc_seen};
		end
	end
	a_weak_pd_on: assert property (o_weak_pd == '1)
		else $error("weak pull-down dropped");
	a_vsel_copy: assert property ($stable(i_cfg.drive_voltage_select)
		|=> o_drive_voltage_target == $past(i_cfg.drive_voltage_select))
		else $error("voltage target not following select");
	a_locked_hiz: assert property ((o_low_rail_lockout || o_high_rail_lockout)
		|-> o_gate_oe == '0) else $error("gate driven while locked");
	a_oe_whole: assert property (o_gate_oe == '1
		|| (o_gate_oe == '0 && o_gate_drive == '0))
		else $error("partial drive or drive in high-Z");
	a_fault_pin: assert property (!o_fault_pin_n
		&& o_fault_pin_n_oe == (o_low_rail_fault | o_high_rail_fault))
		else $error("fault pin disagrees with faults");
	a_low_trip: assert property ($rose(o_low_rail_fault)
		|-> o_low_rail_lockout && !$past(o_low_rail_lockout))
		else $error("low fault without fresh lockout");
	a_lock_hold: assert property ((!i_low_side_pump_rail.above_rise)[*5]
		##1 o_low_rail_lockout |=> o_low_rail_lockout)
		else $error("low lockout released without rise");
	a_strong_idle: assert property (o_gate_oe != '0 |-> o_strong_pd == '0)
		else $error("strong pull-down while driving");
	a_pc_needs_en: assert property ($rose(o_precharge_on)
		|-> $past(i_cfg.low_rail_precharge_enable)) else $error("pre-charge not enabled");
	a_pc_once: assert property (pc_seen |-> !o_precharge_on)
		else $error("second pre-charge");
endmodule
bind gdsc_top gdsc_props #(.NUM_GATES(NUM_GATES)) i_props (.i_ref_clk, .i_rst_n, .i_cfg,
	.i_low_side_pump_rail, .o_drive_voltage_target, .o_precharge_on, .o_gate_drive,
	.o_gate_oe, .o_weak_pd, .o_strong_pd, .o_low_rail_lockout, .o_high_rail_lockout,
	.o_low_rail_fault, .o_high_rail_fault, .o_fault_pin_n, .o_fault_pin_n_oe);
`default_nettype wire

// file: tb/gdsc_host_model.sv
// Host model: enable pin, PWM lines and configuration towards the device
`default_nettype none
module gdsc_host_model (
	// Clock
	input  wire logic                i_ref_clk,
	// Requests from the bench
	input  wire logic                i_en_req,
	input  wire logic [5:0]          i_pwm_req,
	input  wire gdsc_pkg::gdsc_cfg_t i_cfg_req,
	// Pins towards the device
	output var logic                 o_driver_enable_pin = 1'b0,
	output var logic [5:0]           o_pwm = 6'h00,
	output var gdsc_pkg::gdsc_cfg_t  o_cfg = 6'h00
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pins move just after the edge, as a timer output would
	always @(posedge i_ref_clk) begin
		o_driver_enable_pin <= i_en_req;
		o_pwm <= i_pwm_req;
		o_cfg <= i_cfg_req;
	end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the gate drive supply control block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PC_CYC = 20; // Short pre-charge keeps the run brief
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic en_req = 1'b0;
	logic clr = 1'b0;
	logic wsel = 1'b0;
	logic [5:0] pwm_req = 6'h00;
	logic [5:0] vgs = 6'h00;
	logic [7:0] h, mn, mx;
	gdsc_pkg::gdsc_cfg_t cfg_req = 6'h10;
	gdsc_pkg::gdsc_rail_cmp_t rail [2] = '{2'h0, 2'h0};
	wire logic en_pin, pclk, pc_on, llk, hlk, lft, hft, fp, fpoe, watch;
	wire logic [5:0] pwm, gd, goe, wpd, spd;
	wire logic [1:0] vt;
	wire gdsc_pkg::gdsc_cfg_t cfg;
	int err_count = 0;
	int checks = 0;
	// Voltage select, pump clock select, expected half period
	logic [11:0] rows [4] = '{{2'h3, 2'h0, 8'(`GDSC_HALF0)}, {2'h2, 2'h1, 8'(`GDSC_HALF1)},
		{2'h0, 2'h2, 8'(`GDSC_HALF2)}, {2'h1, 2'h3, 8'(`GDSC_HALF3)}};
	assign watch = wsel ? pc_on : pclk;
	always #12.5 i_ref_clk = ~i_ref_clk;
	gdsc_host_model i_host (.i_ref_clk(i_ref_clk), .i_en_req(en_req), .i_pwm_req(pwm_req),
		.i_cfg_req(cfg_req), .o_driver_enable_pin(en_pin), .o_pwm(pwm), .o_cfg(cfg));
	gdsc_top #(.PRECHARGE_CYC(PC_CYC)) i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_cfg(cfg), .i_fault_clear(clr), .i_driver_enable_pin(en_pin), .i_pwm(pwm),
		.i_low_side_pump_rail(rail[0]), .i_high_side_pump_rail(rail[1]),
		.i_gate_vgs_high(vgs), .o_drive_voltage_target(vt), .o_pump_clk(pclk),
		.o_precharge_on(pc_on), .o_gate_drive(gd), .o_gate_oe(goe), .o_weak_pd(wpd),
		.o_strong_pd(spd), .o_low_rail_lockout(llk), .o_high_rail_lockout(hlk),
		.o_low_rail_fault(lft), .o_high_rail_fault(hft), .o_fault_pin_n(fp),
		.o_fault_pin_n_oe(fpoe));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task test_done;
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask
	// Wait for the watched level to change, then count how long the new level lasts
	task meas(output logic [7:0] len);
		logic p;
		int n;
		// Start off the launching edge so the first level is settled
		cyc(1);
		p = watch;
		n = 0;
		while (watch === p && n < 300) begin
			cyc(1);
			n++;
		end
		p = watch;
		len = 8'h00;
		while (watch === p && len < 8'hFF) begin
			cyc(1);
			len++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the sequence needs well under 5000 cycles
	initial begin
		#(25 * 20000);
		err_count++;
		test_done;
	end
	initial begin
		cyc(1);
		chk({llk, hlk, lft, hft, fpoe, pc_on, 2'h0}, 8'hC0);
		chk(wpd, 6'h3F);
		repeat (2) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		wsel = 1'b1;
		meas(h);
		chk(h, 8'(PC_CYC));
		chk({lft, hft, fpoe}, 3'h0);
		// Rails come up, driver enabled with a PWM pattern
		@(posedge i_ref_clk) rail <= '{2'h3, 2'h3};
		en_req <= 1'b1;
		pwm_req <= 6'h2A;
		cyc(10);
		chk({llk, hlk, gd}, 8'h2A);
		chk(goe, 6'h3F);
		wsel = 1'b0;
		// Table of voltage and pump clock selects
		for (int i = 0; i < 4; i++) begin
			@(posedge i_ref_clk) cfg_req <= {2'h1, rows[i][9:8], rows[i][11:10]};
			meas(h);
			meas(h);
			chk(vt, rows[i][11:10]);
			chk(h, rows[i][7:0]);
		end
		// Spread spectrum sweeps the half period over its whole range
		@(posedge i_ref_clk) cfg_req.spread_enable <= 1'b1;
		mn = 8'hFF;
		mx = 8'h00;
		repeat (34) begin
			meas(h);
			mn = (h < mn) ? h : mn;
			mx = (h > mx) ? h : mx;
		end
		chk(mn, 8'(`GDSC_HALF3));
		chk(mx, 8'(`GDSC_HALF3) + `GDSC_SPREAD_MAX);
		@(posedge i_ref_clk) cfg_req.spread_enable <= 1'b0;
		// Each rail drops, recovers, then the sticky fault is cleared
		for (int k = 0; k < 2; k++) begin
			@(posedge i_ref_clk) rail[k] <= 2'h0;
			cyc(8);
			chk({goe, fpoe, fp}, 8'h02);
			chk({lft, hft}, (k == 0) ? 2'h2 : 2'h1);
			@(posedge i_ref_clk) rail[k] <= 2'h3;
			cyc(8);
			chk({goe, fpoe}, 7'h7F);
			@(posedge i_ref_clk) clr <= 1'b1;
			@(posedge i_ref_clk) clr <= 1'b0;
			cyc(3);
			chk({lft, hft, fpoe}, 3'h0);
		end
		// Driver off: rising gate voltages get the strong pull-down
		@(posedge i_ref_clk) en_req <= 1'b0;
		vgs <= 6'h15;
		cyc(8);
		chk(spd, 6'h15);
		chk({goe, wpd[1:0]}, 8'h03);
		chk(pc_on, 1'b0);
		@(posedge i_ref_clk) vgs <= 6'h00;
		// A new power-up allows one more pre-charge
		@(posedge i_ref_clk) i_rst_n <= 1'b0;
		@(posedge i_ref_clk) i_rst_n <= 1'b1;
		wsel = 1'b1;
		meas(h);
		chk(h, 8'(PC_CYC));
		test_done;
	end
endmodule
`default_nettype wire
